// *** common/bpc_params.svh ***
// offsets, field positions, reset values and timing counts of the batch pulse counter
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

`define BPC_A_CTRL 8'h00
`define BPC_A_ADJ 8'h04
`define BPC_A_ADV 8'h08
`define BPC_A_DIV 8'h0C
`define BPC_A_DLY 8'h10
`define BPC_A_HOLD1 8'h14
`define BPC_A_HOLD2 8'h18
`define BPC_A_COUNT 8'h1C
`define BPC_A_STAT 8'h20

`define BPC_F_START 0
`define BPC_F_DOWN 1
`define BPC_F_BATCH 2
`define BPC_F_AUTO 3
`define BPC_F_POL1 4
`define BPC_F_POL2 5

`define BPC_RST_CTRL 6'h34
`define BPC_RST_DIV 16'h0001

`define BPC_MAXV 10'h3E7
`define BPC_FULL 11'h3E8

`define BPC_CLK_PER_NS 5
`define BPC_TICK_NS 100000000
`define BPC_TICK_CYC (`BPC_TICK_NS / `BPC_CLK_PER_NS)

`endif

// *** common/bpc_pkg.sv ***
// types of the batch pulse counter
package bpc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DELAY} bpc_state_type;
endpackage : bpc_pkg

// *** logic/bpc_top.sv ***
// batch pulse counter with two-relay batch control and an APB register file
// Function
// - pulses are divided by the prescale divisor before reaching the result
// - result is three decades, wrapping 999 to 000 and 000 to 999
// - threshold covers 1 to 1000, a stored 000 meaning 1000
// - a cycle starts on the restart key, clear/start input or register write
// - start clears the count going up, loads the adjuster value going down
// - lamp lights from start until the threshold (up) or zero (down)
// - hold stops counting without touching cycle or relay state
// - stop ends both cycles and drives both relays inactive
// - threshold is latched from the adjuster at every start
// - auto restart after a delay from the fine threshold, lamp flashing
// - reset clears the count to 000 as well as the cycle state
// - counting and relay control run regardless of menu state
// - batch mode uses adjuster for fine relay, advance for main relay
// - batch up: zero, both relays on, main off at thr-adv, fine at thr
// - advance above threshold keeps the main relay off at start
// - batch down: load adj, main off at adv-1, fine off at zero
// - each relay output level follows that relay's polarity setting
// - zero hold time keeps a relay inactive until the next start
`include "bpc_params.svh"
`timescale 1ns/100ps
module bpc_top #(
  parameter int DIV_W = 16,
  parameter int TICK_CYC = `BPC_TICK_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // field inputs
  input wire logic PULSE_IN,
  input wire logic HOLD_IN,
  input wire logic STOP_IN,
  input wire logic CLEAR_START_IN,
  input wire logic CYCLE_RESTART_KEY,
  // relays and lamp
  output logic FINE_VALVE_RELAY,
  output logic MAIN_VALVE_RELAY,
  output logic CYCLE_LAMP
);
  import bpc_pkg::*;

  // input synchronisers; stage one feeds stage two only
  logic [4:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
    end else begin
      s1_reg <= {CYCLE_RESTART_KEY, CLEAR_START_IN, STOP_IN, HOLD_IN, PULSE_IN};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic pulse_e, hold, stop, clr_e, key_e;
  assign pulse_e = s2_reg[0] & ~s3_reg[0];
  assign hold = s2_reg[1];
  assign stop = s2_reg[2];
  // clear/start acts on its rising edge so a held level does not restart forever
  assign clr_e = s2_reg[3] & ~s3_reg[3];
  assign key_e = s2_reg[4] & ~s3_reg[4];

  // apb: one wait state, write and read take effect where pready is high
  logic [5:0] ctrl_reg, ctrl_next;
  logic [9:0] adj_reg, adj_next, adv_reg, adv_next, dly_reg, dly_next;
  logic [9:0] ht_reg [2];
  logic [9:0] ht_next [2];
  logic [DIV_W-1:0] div_reg, div_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, wr_go, sw_start, hit_map;
  logic [31:0] rd_val;

  // core state
  bpc_state_type st_reg, st_next;
  logic [9:0] cnt_reg, cnt_next, dcnt_reg, dcnt_next;
  logic [10:0] units_reg, units_next, thr_reg, thr_next;
  logic [DIV_W-1:0] pre_reg, pre_next;
  logic [1:0] act_reg, act_next, done_reg, done_next;
  logic [9:0] hc_reg [2];
  logic [9:0] hc_next [2];
  logic [31:0] tcnt_reg, tcnt_next;
  logic flash_reg, flash_next;
  logic fine_reg, fine_next, main_reg, main_next, lamp_reg, lamp_next;

  assign wr_go = PSEL & PENABLE & PWRITE & PREADY;
  assign sw_start = wr_go && PADDR == `BPC_A_CTRL && PWDATA[`BPC_F_START];

  always_comb begin
    rd_val = 32'h00000000;
    hit_map = 1'b1;
    if (PADDR == `BPC_A_CTRL) begin
      rd_val = {26'h0000000, ctrl_reg};
    end else if (PADDR == `BPC_A_ADJ) begin
      rd_val = {22'h000000, adj_reg};
    end else if (PADDR == `BPC_A_ADV) begin
      rd_val = {22'h000000, adv_reg};
    end else if (PADDR == `BPC_A_DIV) begin
      rd_val = 32'(div_reg);
    end else if (PADDR == `BPC_A_DLY) begin
      rd_val = {22'h000000, dly_reg};
    end else if (PADDR == `BPC_A_HOLD1) begin
      rd_val = {22'h000000, ht_reg[0]};
    end else if (PADDR == `BPC_A_HOLD2) begin
      rd_val = {22'h000000, ht_reg[1]};
    end else if (PADDR == `BPC_A_COUNT) begin
      rd_val = {22'h000000, cnt_reg};
    end else if (PADDR == `BPC_A_STAT) begin
      rd_val = {17'h00000, thr_reg, act_reg, st_reg};
    end else begin
      hit_map = 1'b0;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    adj_next = adj_reg;
    adv_next = adv_reg;
    dly_next = dly_reg;
    div_next = div_reg;
    ht_next = ht_reg;
    pready_next = PSEL & PENABLE & ~PREADY;
    prdata_next = PRDATA;
    pslverr_next = 1'b0;
    if (PSEL & PENABLE & ~PREADY) begin
      prdata_next = PWRITE ? 32'h00000000 : rd_val;
      pslverr_next = ~hit_map;
    end
    if (wr_go) begin
      if (PADDR == `BPC_A_CTRL) begin
        ctrl_next = {PWDATA[5:1], 1'b0};
      end else if (PADDR == `BPC_A_ADJ && PWDATA[9:0] <= `BPC_MAXV) begin
        adj_next = PWDATA[9:0];
      end else if (PADDR == `BPC_A_ADV && PWDATA[9:0] <= `BPC_MAXV) begin
        adv_next = PWDATA[9:0];
      end else if (PADDR == `BPC_A_DIV) begin
        div_next = PWDATA[DIV_W-1:0];
      end else if (PADDR == `BPC_A_DLY && PWDATA[9:0] <= `BPC_MAXV) begin
        dly_next = PWDATA[9:0];
      end else if (PADDR == `BPC_A_HOLD1) begin
        ht_next[0] = PWDATA[9:0];
      end else if (PADDR == `BPC_A_HOLD2) begin
        ht_next[1] = PWDATA[9:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_reg <= `BPC_RST_CTRL;
      adj_reg <= 10'h000;
      adv_reg <= 10'h000;
      dly_reg <= 10'h000;
      div_reg <= DIV_W'(`BPC_RST_DIV);
      ht_reg <= '{10'h000, 10'h000};
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      adj_reg <= adj_next;
      adv_reg <= adv_next;
      dly_reg <= dly_next;
      div_reg <= div_next;
      ht_reg <= ht_next;
      PREADY <= pready_next;
      PRDATA <= prdata_next;
      PSLVERR <= pslverr_next;
    end
  end

  // counting and relay control; nothing here looks at menu state
  logic down, batch, tick, start, auto_go;
  logic [10:0] new_thr, mthr;
  logic [DIV_W-1:0] div_eff;
  assign down = ctrl_reg[`BPC_F_DOWN];
  assign batch = ctrl_reg[`BPC_F_BATCH];
  assign tick = tcnt_reg == 32'(TICK_CYC - 1);
  assign new_thr = (adj_reg == 10'h000) ? `BPC_FULL : {1'b0, adj_reg};
  assign div_eff = (div_reg == '0) ? DIV_W'(1) : div_reg;
  assign auto_go = st_reg == ST_DELAY && dcnt_reg == 10'h000;
  assign start = key_e | clr_e | sw_start | auto_go;
  // main relay point in units since start; going down it is one unit later
  assign mthr = down ? thr_reg - {1'b0, adv_reg} + 11'h001 : thr_reg - {1'b0, adv_reg};

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    dcnt_next = dcnt_reg;
    units_next = units_reg;
    thr_next = thr_reg;
    pre_next = pre_reg;
    act_next = act_reg;
    done_next = done_reg;
    hc_next = hc_reg;
    tcnt_next = tick ? 32'h00000000 : tcnt_reg + 32'h00000001;
    flash_next = tick ? ~flash_reg : flash_reg;
    if (stop) begin
      st_next = ST_IDLE;
      act_next = 2'b00;
      done_next = 2'b11;
      hc_next = '{10'h000, 10'h000};
    end else if (start) begin
      st_next = ST_RUN;
      thr_next = new_thr;
      units_next = 11'h000;
      pre_next = '0;
      // load the adjuster itself: a stored 000 must show 000, not an out-of-range 1000
      cnt_next = down ? adj_reg : 10'h000;
      act_next[0] = 1'b1;
      // with no room for the advance the main valve stays shut
      act_next[1] = batch && {1'b0, adv_reg} <= new_thr;
      done_next = {~act_next[1], 1'b0};
      hc_next = '{10'h000, 10'h000};
      flash_next = 1'b0;
    end else begin
      if (pulse_e && !hold) begin
        if (pre_reg + DIV_W'(1) >= div_eff) begin
          pre_next = '0;
          if (down) begin
            cnt_next = (cnt_reg == 10'h000) ? `BPC_MAXV : cnt_reg - 10'h001;
          end else begin
            cnt_next = (cnt_reg == `BPC_MAXV) ? 10'h000 : cnt_reg + 10'h001;
          end
          if (st_reg != ST_IDLE && units_reg != 11'h7FF) begin
            units_next = units_reg + 11'h001;
          end
        end else begin
          pre_next = pre_reg + DIV_W'(1);
        end
      end else if (wr_go && PADDR == `BPC_A_COUNT && PWDATA[9:0] <= `BPC_MAXV) begin
        cnt_next = PWDATA[9:0];
      end
      // relay timers run on the 0.1 s tick once a threshold was passed
      for (int i = 0; i < 2; i++) begin
        if (!act_reg[i] && hc_reg[i] != 10'h000 && tick) begin
          hc_next[i] = hc_reg[i] - 10'h001;
          if (hc_reg[i] == 10'h001) begin
            act_next[i] = 1'b1;
          end
        end
      end
      if (st_reg != ST_IDLE && !done_reg[1] && units_reg >= mthr) begin
        done_next[1] = 1'b1;
        act_next[1] = 1'b0;
        hc_next[1] = ht_reg[1];
      end
      if (st_reg != ST_IDLE && !done_reg[0] && units_reg >= thr_reg) begin
        done_next[0] = 1'b1;
        act_next[0] = 1'b0;
        hc_next[0] = ht_reg[0];
      end
      if (st_reg == ST_RUN && units_reg >= thr_reg) begin
        st_next = ctrl_reg[`BPC_F_AUTO] ? ST_DELAY : ST_IDLE;
        dcnt_next = dly_reg;
      end else if (st_reg == ST_DELAY && tick) begin
        dcnt_next = dcnt_reg - 10'h001;
      end
    end
    fine_next = act_next[0] ^ ~ctrl_reg[`BPC_F_POL1];
    main_next = act_next[1] ^ ~ctrl_reg[`BPC_F_POL2];
    lamp_next = st_next == ST_RUN || (st_next == ST_DELAY && flash_next);
  end

  // reset leaves cycles idle so restart needs a manual start
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 10'h000;
      dcnt_reg <= 10'h000;
      units_reg <= 11'h000;
      thr_reg <= `BPC_FULL;
      pre_reg <= '0;
      act_reg <= 2'b00;
      done_reg <= 2'b11;
      hc_reg <= '{10'h000, 10'h000};
      tcnt_reg <= 32'h00000000;
      flash_reg <= 1'b0;
      FINE_VALVE_RELAY <= 1'b0;
      MAIN_VALVE_RELAY <= 1'b0;
      CYCLE_LAMP <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      dcnt_reg <= dcnt_next;
      units_reg <= units_next;
      thr_reg <= thr_next;
      pre_reg <= pre_next;
      act_reg <= act_next;
      done_reg <= done_next;
      hc_reg <= hc_next;
      tcnt_reg <= tcnt_next;
      flash_reg <= flash_next;
      FINE_VALVE_RELAY <= fine_next;
      MAIN_VALVE_RELAY <= main_next;
      CYCLE_LAMP <= lamp_next;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_wrap_up: assert property (!stop && !start && !down && !hold && pulse_e && cnt_reg == `BPC_MAXV
    && pre_reg + DIV_W'(1) >= div_eff |=> cnt_reg == 10'h000) else $error("count did not wrap to 000");
  a_wrap_down: assert property (!stop && !start && down && !hold && pulse_e && cnt_reg == 10'h000
    && pre_reg + DIV_W'(1) >= div_eff |=> cnt_reg == `BPC_MAXV) else $error("count did not wrap to 999");
  a_stop_relays: assert property (stop |=> act_reg == 2'b00 && st_reg == ST_IDLE && FINE_VALVE_RELAY ==
    ~$past(ctrl_reg[`BPC_F_POL1]) && MAIN_VALVE_RELAY == ~$past(ctrl_reg[`BPC_F_POL2])) else $error("stop left a relay on");
  a_hold_freeze: assert property (hold && !stop && !start && !wr_go |=> $stable(cnt_reg)
    && $stable(units_reg)) else $error("count moved while held");
  a_start_load: assert property (start && !stop |=> st_reg == ST_RUN && units_reg == 11'h000
    && cnt_reg == ($past(down) ? $past(adj_reg) : 10'h000)) else $error("start did not load the count");
  a_thr_latch: assert property (start && !stop && adj_reg == 10'h000 |=> thr_reg == `BPC_FULL)
    else $error("000 did not latch as 1000");
  a_adv_skip: assert property (start && !stop && {1'b0, adv_reg} > new_thr |=> !act_reg[1]
    ##1 !act_reg[1]) else $error("main relay opened with advance above threshold");
  a_lamp_run: assert property (st_reg == ST_RUN |-> CYCLE_LAMP) else $error("lamp off in a running cycle");
  a_fine_end: assert property (st_reg == ST_RUN && !done_reg[0] && units_reg >= thr_reg && !stop
    && !start |=> !act_reg[0] && st_reg != ST_RUN) else $error("fine relay missed its threshold");
endmodule : bpc_top

// *** verif/batch_pulse_counter_tb.sv ***
// self-checking bench of the batch pulse counter
`include "bpc_params.svh"
`timescale 1ns/100ps
module batch_pulse_counter_tb;
  import bpc_pkg::*;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rv;
  logic PULSE_IN, HOLD_IN, STOP_IN, CLEAR_START_IN, CYCLE_RESTART_KEY;
  logic FINE_VALVE_RELAY, MAIN_VALVE_RELAY, CYCLE_LAMP, ev;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // short tick keeps delay counts to tens of cycles
  localparam int TICK = 10;
  bpc_top #(
    .DIV_W(16),
    .TICK_CYC(TICK)
  ) DUT (
    .CLK(CLK),
    .RST(RST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .PULSE_IN(PULSE_IN),
    .HOLD_IN(HOLD_IN),
    .STOP_IN(STOP_IN),
    .CLEAR_START_IN(CLEAR_START_IN),
    .CYCLE_RESTART_KEY(CYCLE_RESTART_KEY),
    .FINE_VALVE_RELAY(FINE_VALVE_RELAY),
    .MAIN_VALVE_RELAY(MAIN_VALVE_RELAY),
    .CYCLE_LAMP(CYCLE_LAMP)
  );
  bpc_field_model u_field (
    .CLK(CLK),
    .PULSE_IN(PULSE_IN),
    .HOLD_IN(HOLD_IN),
    .STOP_IN(STOP_IN),
    .CLEAR_START_IN(CLEAR_START_IN),
    .CYCLE_RESTART_KEY(CYCLE_RESTART_KEY)
  );
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic end_sim;
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rv = PRDATA;
    ev = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    chk(rv & mask, exp);
  endtask : rdc
  // order of the bits: main relay, fine relay, lamp
  task automatic pins(input logic [2:0] exp);
    chk({29'h0, MAIN_VALVE_RELAY, FINE_VALVE_RELAY, CYCLE_LAMP}, {29'h0, exp});
  endtask : pins
  task automatic t_reset;
    pins(3'h0);
    rdc(`BPC_A_CTRL, 32'h34, 32'hFFFFFFFF);
    rdc(`BPC_A_DIV, 32'h1, 32'hFFFFFFFF);
    // idle, relays inactive, reset threshold of 1000 units
    rdc(`BPC_A_STAT, 32'h3E80, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, ev}, 32'h1);
  endtask : t_reset
  task automatic t_std_up;
    wr(`BPC_A_CTRL, 32'h30);
    wr(`BPC_A_DIV, 32'h2);
    wr(`BPC_A_ADJ, 32'h3);
    wr(`BPC_A_COUNT, 32'h7);
    u_field.press(1'b1);
    rdc(`BPC_A_COUNT, 32'h0, 32'hFFFFFFFF);
    u_field.pulses(5);
    rdc(`BPC_A_COUNT, 32'h2, 32'hFFFFFFFF);
    chk({30'h0, MAIN_VALVE_RELAY, CYCLE_LAMP}, 32'h1);
    u_field.pulses(1);
    chk({30'h0, MAIN_VALVE_RELAY, CYCLE_LAMP}, 32'h0);
  endtask : t_std_up
  task automatic t_batch_up;
    wr(`BPC_A_CTRL, 32'h34);
    wr(`BPC_A_DIV, 32'h1);
    wr(`BPC_A_ADJ, 32'h4);
    wr(`BPC_A_ADV, 32'h2);
    u_field.press(1'b0);
    pins(3'h7);
    wr(`BPC_A_ADJ, 32'h9);
    rdc(`BPC_A_STAT, 32'h4D, 32'h7FFF);
    u_field.levels(1'b1, 1'b0);
    u_field.pulses(3);
    rdc(`BPC_A_COUNT, 32'h0, 32'hFFFFFFFF);
    pins(3'h7);
    u_field.levels(1'b0, 1'b0);
    u_field.pulses(2);
    pins(3'h3);
    u_field.pulses(2);
    pins(3'h0);
    u_field.pulses(1);
    pins(3'h0);
  endtask : t_batch_up
  task automatic t_batch_down;
    wr(`BPC_A_ADJ, 32'h3);
    wr(`BPC_A_HOLD1, 32'h2);
    // direction first: a start reads the direction that stood before its own write
    wr(`BPC_A_CTRL, 32'h36);
    wr(`BPC_A_CTRL, 32'h37);
    rdc(`BPC_A_COUNT, 32'h3, 32'hFFFFFFFF);
    u_field.pulses(1);
    pins(3'h7);
    u_field.pulses(1);
    pins(3'h3);
    u_field.pulses(1);
    pins(3'h0);
    // a hold time of two ticks brings the fine relay back without a new start
    repeat (30) @(posedge CLK);
    pins(3'h2);
  endtask : t_batch_down
  task automatic t_adv_stop;
    wr(`BPC_A_ADV, 32'h5);
    wr(`BPC_A_CTRL, 32'h34);
    u_field.press(1'b1);
    pins(3'h3);
    wr(`BPC_A_CTRL, 32'h36);
    wr(`BPC_A_CTRL, 32'h37);
    rdc(`BPC_A_COUNT, 32'h3, 32'hFFFFFFFF);
    pins(3'h3);
    u_field.levels(1'b0, 1'b1);
    pins(3'h0);
    rdc(`BPC_A_STAT, 32'h0, 32'h3);
    u_field.press(1'b1);
    pins(3'h0);
    wr(`BPC_A_CTRL, 32'h04);
    repeat (4) @(posedge CLK);
    pins(3'h6);
    u_field.levels(1'b0, 1'b0);
  endtask : t_adv_stop
  task automatic t_wrap_auto;
    wr(`BPC_A_CTRL, 32'h30);
    wr(`BPC_A_ADJ, 32'h0);
    u_field.press(1'b1);
    wr(`BPC_A_COUNT, 32'h3E7);
    u_field.pulses(1);
    rdc(`BPC_A_COUNT, 32'h0, 32'hFFFFFFFF);
    rdc(`BPC_A_STAT, 32'h3E80, 32'h7FF0);
    chk({31'h0, CYCLE_LAMP}, 32'h1);
    wr(`BPC_A_CTRL, 32'h3C);
    wr(`BPC_A_ADJ, 32'h1);
    wr(`BPC_A_ADV, 32'h0);
    wr(`BPC_A_DLY, 32'h3);
    u_field.press(1'b0);
    u_field.pulses(1);
    rdc(`BPC_A_STAT, 32'h2, 32'h3);
    // delay is three ticks of ten cycles
    repeat (40) @(posedge CLK);
    rdc(`BPC_A_STAT, 32'h1, 32'h3);
    u_field.levels(1'b0, 1'b1);
  endtask : t_wrap_auto
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_std_up();
    t_batch_up();
    t_batch_down();
    t_adv_stop();
    t_wrap_auto();
    end_sim();
  end
endmodule : batch_pulse_counter_tb

// *** verif/bpc_field_model.sv ***
// field side model: pulse sensor, control switches and the restart key
`timescale 1ns/100ps
module bpc_field_model (
  // clock
  input wire logic CLK,
  // field signals towards the counter
  output logic PULSE_IN,
  output logic HOLD_IN,
  output logic STOP_IN,
  output logic CLEAR_START_IN,
  output logic CYCLE_RESTART_KEY
);
  initial begin
    PULSE_IN = 1'b0;
    HOLD_IN = 1'b0;
    STOP_IN = 1'b0;
    CLEAR_START_IN = 1'b0;
    CYCLE_RESTART_KEY = 1'b0;
  end
  // no menu key here: the two second press for menu entry stays with the operator
  // two cycles per level, so the synchroniser never merges two pulses
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      PULSE_IN <= 1'b1;
      repeat (2) @(posedge CLK);
      PULSE_IN <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    repeat (6) @(posedge CLK);
  endtask : pulses
  // start by key or by the clear/start input
  task automatic press(input logic key);
    @(posedge CLK);
    if (key) CYCLE_RESTART_KEY <= 1'b1;
    else CLEAR_START_IN <= 1'b1;
    repeat (3) @(posedge CLK);
    CYCLE_RESTART_KEY <= 1'b0;
    CLEAR_START_IN <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask : press
  task automatic levels(input logic hold, input logic stop);
    @(posedge CLK);
    HOLD_IN <= hold;
    STOP_IN <= stop;
    repeat (6) @(posedge CLK);
  endtask : levels
endmodule : bpc_field_model
